// ===== rtl/pafs_cfg.svh
// Constants for the port A pin function select block.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef PAFS_CFG_SVH
`define PAFS_CFG_SVH

// Register offsets; none are printed, so these are local choices.
`define PAFS_OFS_LOW     4'h0
`define PAFS_OFS_PINS89  4'h4
`define PAFS_OFS_HIGH    4'h8

// Field positions.
`define PAFS_LOW_PIN2_LSB 8
`define PAFS_LOW_PIN1_LSB 4
`define PAFS_LOW_PIN0_LSB 0
`define PAFS_P89_PIN9_LSB 4
`define PAFS_P89_PIN8_LSB 0

// Reset values and writable masks.
`define PAFS_RST_VALUE    16'h0000
`define PAFS_LOW_WMASK    16'h0777
`define PAFS_P89_WMASK    16'h0077

`endif

// ===== rtl/pafs_pkg.sv
// Types shared by the port A pin function select design.
// Assumes nothing of its surroundings.
package pafs_pkg;

  typedef logic [2:0] pafs_mode_t;

  // Pin function selected for one pin.
  typedef enum logic [2:0] {
    PAFS_FN_PORT   = 3'h0,
    PAFS_FN_ALT1   = 3'h1,
    PAFS_FN_ALT3   = 3'h3,
    PAFS_FN_ALT6   = 3'h6,
    PAFS_FN_ALT7   = 3'h7
  } pafs_fn_e;

endpackage : pafs_pkg

// ===== rtl/pafs_sync.sv
// Two-flop synchroniser for an asynchronous pin level.
// Assumes clk is the peripheral clock and sys_rst is asynchronous, active high.
`timescale 1ns/100ps
module pafs_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_reg <= RST_VAL;
      sync_out   <= RST_VAL;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule : pafs_sync

// ===== rtl/pafs_pinmux.sv
// One pin's function multiplexer: mode code to peripheral or port routing.
// Assumes pin input was synchronised upstream; outputs are combinational.
`timescale 1ns/100ps
module pafs_pinmux #(
  parameter logic [2:0] CODE_A = 3'h1,
  parameter logic [2:0] CODE_B = 3'h7,
  parameter logic       A_OUT  = 1'b0,
  parameter logic       B_OUT  = 1'b0
) (
  input  wire logic [2:0] mode,
  input  wire logic       port_out,
  input  wire logic       port_oe,
  input  wire logic       a_out,
  input  wire logic       a_oe,
  input  wire logic       b_out,
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe,
  output logic            port_in,
  output logic            a_in,
  output logic            b_in
);
  // Inputs of unselected peripheral functions sit at their idle high level; port_in always follows the pin.
  always_comb begin
    pin_out = 1'b0;
    pin_oe  = 1'b0;
    port_in = pin_in;
    a_in    = 1'b1;
    b_in    = 1'b1;
    if (mode == 3'h0) begin
      pin_out = port_out;
      pin_oe  = port_oe;
    end else if (mode == CODE_A) begin
      a_in    = pin_in;
      pin_out = a_out;
      pin_oe  = A_OUT & a_oe;
    end else if (mode == CODE_B) begin
      b_in    = pin_in;
      pin_out = b_out;
      pin_oe  = B_OUT;
    end
  end
endmodule : pafs_pinmux

// ===== rtl/pafs_top.sv
// Port A pin function select: control registers and the pin routing for
// pins 0, 1, 2, 8 and 9.
// Assumes a single peripheral clock and a plain strobe register port.
//
// How it works
// R01: Pin 2 mode: 000 port, 001 serial 0 clock, 011 interrupt request 0.
// R02: Pin 1 mode: 000 port, 001 serial 0 transmit, 111 output-disable 1.
// R03: Pin 0 mode: 000 port, 001 serial 0 receive, 111 output-disable 0.
// R04: Pin 9 mode: 000 port, 001 timer clock D, 110 serial 2 tx, 111 disable 8.
// R05: Pin 8 mode: 000 port, 001 timer clock C, 110 serial 2 receive.
// R06: Software writes only listed codes; others are undefined.
// R07: Reserved bits 11, 7 and 3 read zero; software writes zero.
// R08: Small package: high register and pin 8/9 bits 15 to 7 read zero.
// R09: Strap low forces pin 8 to test-data in, pin 9 to test-data out; pin 8's serial 2 receive is not gated by the strap.
// R10: Fields at 10:8, 6:4, 2:0; pin 9 at 6:4, pin 8 at 2:0.
// R11: All mode fields reset to zero, so pins start as port I/O.
`timescale 1ns/100ps
`include "pafs_cfg.svh"
module pafs_top #(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  input  wire logic              debug_emulator_strap_n,
  input  wire logic [9:0]        pin_in,
  output logic      [9:0]        pin_out,
  output logic      [9:0]        pin_oe,
  input  wire logic [9:0]        port_out,
  input  wire logic [9:0]        port_oe,
  output logic      [9:0]        port_in,
  input  wire logic              serial0_clock_out,
  input  wire logic              serial0_clock_oe,
  output logic                   serial0_clock_in,
  input  wire logic              serial0_transmit,
  output logic                   serial0_receive,
  input  wire logic              serial2_transmit,
  output logic                   serial2_receive,
  output logic                   interrupt_request_0,
  output logic                   output_disable_request_0,
  output logic                   output_disable_request_1,
  output logic                   output_disable_request_8,
  output logic                   timer_ext_clock_c,
  output logic                   timer_ext_clock_d,
  output logic                   test_data_in,
  input  wire logic              test_data_out,
  output logic                   debug_active
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [4:0] pin_sync;
  logic       strap_sync_n;
  localparam int PIN_IDX [5] = '{0, 1, 2, 8, 9};

  // Only the pads this block routes are synchronised; the others never
  // reach a peripheral here, so their flops would be dead weight.
  // Every pad-to-peripheral path therefore lags the pad by two clocks.

  for (genvar g = 0; g < 5; g++) begin : g_pin_sync
    pafs_sync #(.RST_VAL(1'b1)) u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (pin_in[PIN_IDX[g]]),
      .sync_out (pin_sync[g])
    );
  end

  // The strap resets high so a floating or late strap leaves debug off.
  pafs_sync #(.RST_VAL(1'b1)) u_strap_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (debug_emulator_strap_n),
    .sync_out (strap_sync_n)
  );

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [15:0] ctrl_low_reg;
  logic [15:0] ctrl_pins89_reg;
  logic        dbg_reg;

  // Reserved bits are masked as they are written, so a read shows zero
  // even when software breaks the write-zero rule. The cost is a few AND
  // gates; the gain is that no stored bit ever needs a read-side mask.

  // Address compare shared by the write and read decoders.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_low_reg <= `PAFS_RST_VALUE; // R11
    end else if (reg_wr && hit(reg_addr, `PAFS_OFS_LOW)) begin
      ctrl_low_reg <= reg_wdata & `PAFS_LOW_WMASK; // R07 R10
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_pins89_reg <= `PAFS_RST_VALUE; // R11
    end else if (reg_wr && hit(reg_addr, `PAFS_OFS_PINS89)) begin
      ctrl_pins89_reg <= reg_wdata & `PAFS_P89_WMASK; // R08 R07
    end
  end

  // Read data stand only in the cycle after the strobe. The high
  // register has no storage and reads zero, as does an unmapped address.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (hit(reg_addr, `PAFS_OFS_LOW)) begin
        reg_rdata <= ctrl_low_reg;
      end else if (hit(reg_addr, `PAFS_OFS_PINS89)) begin
        reg_rdata <= ctrl_pins89_reg;
      end else begin
        reg_rdata <= 16'h0000; // R08
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbg_reg <= 1'b0;
    end else begin
      dbg_reg <= ~strap_sync_n; // R09
    end
  end

  // Debug mode follows the strap pin three clocks late: two synchroniser
  // flops and this register.
  assign debug_active = dbg_reg;

  // ****************************************************************
  // Mode fields
  // ****************************************************************
  pafs_pkg::pafs_mode_t pin0_mode_field;
  pafs_pkg::pafs_mode_t pin1_mode_field;
  pafs_pkg::pafs_mode_t pin2_mode_field;
  pafs_pkg::pafs_mode_t pin8_mode_field;
  pafs_pkg::pafs_mode_t pin9_mode_field;

  // The fields are plain slices; undefined codes pass through unchanged
  // and are caught by the pin multiplexers below.

  assign pin0_mode_field = ctrl_low_reg[`PAFS_LOW_PIN0_LSB +: 3]; // R10
  assign pin1_mode_field = ctrl_low_reg[`PAFS_LOW_PIN1_LSB +: 3]; // R10
  assign pin2_mode_field = ctrl_low_reg[`PAFS_LOW_PIN2_LSB +: 3]; // R10
  assign pin8_mode_field = ctrl_pins89_reg[`PAFS_P89_PIN8_LSB +: 3]; // R10
  assign pin9_mode_field = ctrl_pins89_reg[`PAFS_P89_PIN9_LSB +: 3]; // R10

  // ****************************************************************
  // Pin routing
  // ****************************************************************
  // Codes outside the listed ones leave the pin undriven and its
  // peripheral inputs idle; software must not use them.
  logic [9:0] mux_out;
  logic [9:0] mux_oe;
  logic [9:0] mux_port_in;

  pafs_pinmux #(
    .CODE_A (pafs_pkg::PAFS_FN_ALT1), .CODE_B (pafs_pkg::PAFS_FN_ALT7),
    .A_OUT  (1'b0), .B_OUT (1'b0)
  ) u_pin0 ( // R03 R06
    .mode     (pin0_mode_field),
    .port_out (port_out[0]),
    .port_oe  (port_oe[0]),
    .a_out    (1'b0),
    .a_oe     (1'b0),
    .b_out    (1'b0),
    .pin_in   (pin_sync[0]),
    .pin_out  (mux_out[0]),
    .pin_oe   (mux_oe[0]),
    .port_in  (mux_port_in[0]),
    .a_in     (serial0_receive),
    .b_in     (output_disable_request_0)
  );

  pafs_pinmux #(
    .CODE_A (pafs_pkg::PAFS_FN_ALT1), .CODE_B (pafs_pkg::PAFS_FN_ALT7),
    .A_OUT  (1'b1), .B_OUT (1'b0)
  ) u_pin1 ( // R02
    .mode     (pin1_mode_field),
    .port_out (port_out[1]),
    .port_oe  (port_oe[1]),
    .a_out    (serial0_transmit),
    .a_oe     (1'b1),
    .b_out    (1'b0),
    .pin_in   (pin_sync[1]),
    .pin_out  (mux_out[1]),
    .pin_oe   (mux_oe[1]),
    .port_in  (mux_port_in[1]),
    .a_in     (),
    .b_in     (output_disable_request_1)
  );

  pafs_pinmux #(
    .CODE_A (pafs_pkg::PAFS_FN_ALT1), .CODE_B (pafs_pkg::PAFS_FN_ALT3),
    .A_OUT  (1'b1), .B_OUT (1'b0)
  ) u_pin2 ( // R01
    .mode     (pin2_mode_field),
    .port_out (port_out[2]),
    .port_oe  (port_oe[2]),
    .a_out    (serial0_clock_out),
    .a_oe     (serial0_clock_oe),
    .b_out    (1'b0),
    .pin_in   (pin_sync[2]),
    .pin_out  (mux_out[2]),
    .pin_oe   (mux_oe[2]),
    .port_in  (mux_port_in[2]),
    .a_in     (serial0_clock_in),
    .b_in     (interrupt_request_0)
  );

  logic p8_tclk;
  logic p9_tclk;
  logic p9_odr;

  pafs_pinmux #(
    .CODE_A (pafs_pkg::PAFS_FN_ALT1), .CODE_B (pafs_pkg::PAFS_FN_ALT6),
    .A_OUT  (1'b0), .B_OUT (1'b0)
  ) u_pin8 ( // R05
    .mode     (pin8_mode_field),
    .port_out (port_out[8]),
    .port_oe  (port_oe[8]),
    .a_out    (1'b0),
    .a_oe     (1'b0),
    .b_out    (1'b0),
    .pin_in   (pin_sync[3]),
    .pin_out  (mux_out[8]),
    .pin_oe   (mux_oe[8]),
    .port_in  (mux_port_in[8]),
    .a_in     (p8_tclk),
    .b_in     (serial2_receive)
  );

  pafs_pinmux #(
    .CODE_A (pafs_pkg::PAFS_FN_ALT1), .CODE_B (pafs_pkg::PAFS_FN_ALT6),
    .A_OUT  (1'b0), .B_OUT (1'b1)
  ) u_pin9 ( // R04
    .mode     (pin9_mode_field),
    .port_out (port_out[9]),
    .port_oe  (port_oe[9]),
    .a_out    (1'b0),
    .a_oe     (1'b0),
    .b_out    (serial2_transmit),
    .pin_in   (pin_sync[4]),
    .pin_out  (mux_out[9]),
    .pin_oe   (mux_oe[9]),
    .port_in  (mux_port_in[9]),
    .a_in     (p9_tclk),
    .b_in     ()
  );

  // Pin 9 has a fourth function, handled beside its three-way mux.
  assign p9_odr = (pin9_mode_field == pafs_pkg::PAFS_FN_ALT7) ? pin_sync[4] : 1'b1; // R04

  // ****************************************************************
  // Debug override and pin assembly
  // ****************************************************************
  // While debugging, pins 8 and 9 drop the mux pad and port-input routing; the
  // timer and disable inputs are gated below, but serial2_receive is not.
  always_comb begin
    pin_out    = 10'h000;
    pin_oe     = 10'h000;
    port_in    = 10'h3FF;
    pin_out[0] = mux_out[0];
    pin_oe[0]  = mux_oe[0];
    port_in[0] = mux_port_in[0];
    pin_out[1] = mux_out[1];
    pin_oe[1]  = mux_oe[1];
    port_in[1] = mux_port_in[1];
    pin_out[2] = mux_out[2];
    pin_oe[2]  = mux_oe[2];
    port_in[2] = mux_port_in[2];
    if (dbg_reg) begin
      pin_oe[9]  = 1'b1; // R09
      pin_out[9] = test_data_out; // R09
    end else begin
      pin_out[8] = mux_out[8];
      pin_oe[8]  = mux_oe[8];
      port_in[8] = mux_port_in[8];
      pin_out[9] = mux_out[9];
      pin_oe[9]  = mux_oe[9];
      port_in[9] = mux_port_in[9];
    end
  end

  // ****************************************************************
  // Peripheral inputs of pins 8 and 9
  // ****************************************************************
  // The strap wins over every mode field except pin 8's serial 2 receive. Gating here, after the
  // multiplexers, keeps the timer and disable inputs idle even while a
  // stale mode field still selects them.
  assign test_data_in             = dbg_reg ? pin_sync[3] : 1'b1; // R09
  assign timer_ext_clock_c        = dbg_reg ? 1'b1 : p8_tclk;
  assign timer_ext_clock_d        = dbg_reg ? 1'b1 : p9_tclk;
  assign output_disable_request_8 = dbg_reg ? 1'b1 : p9_odr;

endmodule : pafs_top

// ===== tb/pafs_top_sva.sv
// Concurrent checks on the port A pin function select top.
// Assumes it is bound to pafs_top and watches only that module's ports.
`timescale 1ns/100ps
`include "pafs_cfg.svh"
module pafs_top_sva #(
  parameter int ADDR_W = 4
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  input wire logic              debug_emulator_strap_n,
  input wire logic [9:0]        pin_in,
  input wire logic [9:0]        pin_out,
  input wire logic [9:0]        pin_oe,
  input wire logic              serial0_transmit,
  input wire logic              serial0_receive,
  input wire logic              serial2_transmit,
  input wire logic              interrupt_request_0,
  input wire logic              output_disable_request_1,
  input wire logic              test_data_out,
  input wire logic              debug_active
);
  // ****************************************************************
  // Shadow of the mode registers, rebuilt from the writes on the bus.
  // ****************************************************************
  logic [15:0] low_reg;
  logic [15:0] p89_reg;
  logic [15:0] rd_exp;
  assign rd_exp = (reg_addr == `PAFS_OFS_LOW) ? low_reg :
                  (reg_addr == `PAFS_OFS_PINS89) ? p89_reg : 16'h0000;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_reg <= `PAFS_RST_VALUE;
      p89_reg <= `PAFS_RST_VALUE;
    end else if (reg_wr && reg_addr == `PAFS_OFS_LOW) begin
      low_reg <= reg_wdata & `PAFS_LOW_WMASK;
    end else if (reg_wr && reg_addr == `PAFS_OFS_PINS89) begin
      p89_reg <= reg_wdata & `PAFS_P89_WMASK;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Inputs pass two sync flops, so a mode must hold three edges first.
  sequence s_rx_mode;
    (low_reg[2:0] == 3'h1) [*3];
  endsequence
  sequence s_strap_low;
    (!debug_emulator_strap_n) [*4];
  endsequence
  a_read_data: assert property (reg_rd |=> reg_rdata == $past(rd_exp))
    else $error("read data differs from the register contents");
  a_pin0_receive: assert property (s_rx_mode |-> serial0_receive == $past(pin_in[0], 2))
    else $error("pin 0 receive path wrong");
  a_pin2_interrupt: assert property ((low_reg[10:8] == 3'h3) [*3] |->
    interrupt_request_0 == $past(pin_in[2], 2)) else $error("pin 2 interrupt path wrong");
  a_pin1_transmit: assert property (low_reg[6:4] == 3'h1 |->
    pin_oe[1] && pin_out[1] == serial0_transmit) else $error("pin 1 transmit path wrong");
  a_pin1_disable: assert property ((low_reg[6:4] == 3'h7) [*3] |->
    output_disable_request_1 == $past(pin_in[1], 2)) else $error("pin 1 disable path wrong");
  a_pin9_transmit: assert property (!debug_active && p89_reg[6:4] == 3'h6 |->
    pin_oe[9] && pin_out[9] == serial2_transmit) else $error("pin 9 transmit path wrong");
  a_debug_entry: assert property (s_strap_low |-> debug_active)
    else $error("debug override not entered");
  a_debug_exit: assert property (debug_emulator_strap_n [*4] |-> !debug_active)
    else $error("debug override not left");
  a_debug_pin9: assert property (debug_active |-> pin_oe[9] && pin_out[9] == test_data_out)
    else $error("pin 9 not carrying test data out");
endmodule : pafs_top_sva
bind pafs_top pafs_top_sva #(.ADDR_W(ADDR_W)) u_pafs_top_sva (.clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .debug_emulator_strap_n, .pin_in, .pin_out, .pin_oe,
  .serial0_transmit, .serial0_receive, .serial2_transmit, .interrupt_request_0,
  .output_disable_request_1, .test_data_out, .debug_active);

// ===== tb/pafs_far_model.sv
// Peripherals and pads on the far side of the pin function select.
// Assumes the bench hands it each new drive pattern on stim.
`timescale 1ns/100ps
module pafs_far_model (
  input wire logic        clk,
  input wire logic [34:0] stim,
  input wire logic [9:0]  pin_out,
  input wire logic [9:0]  pin_oe,
  output logic     [9:0]  pin_in,
  output logic     [9:0]  port_out,
  output logic     [9:0]  port_oe,
  output logic            serial0_clock_out,
  output logic            serial0_clock_oe,
  output logic            serial0_transmit,
  output logic            serial2_transmit,
  output logic            test_data_out
);
  // ****************************************************
  // Sources change just after an edge, like real logic.
  // ****************************************************
  logic [34:0] drv_reg = '0;
  always @(posedge clk) drv_reg <= stim;
  assign {test_data_out, serial2_transmit, serial0_transmit, serial0_clock_oe,
          serial0_clock_out, port_oe, port_out} = drv_reg[34:10];
  // A driven pad follows its driver, otherwise the outside level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_reg[9:0]);
endmodule : pafs_far_model

// ===== tb/testbench.sv
// Self-checking bench for the port A pin function select top.
// Assumes the design, its checker and the far-side model are compiled first.
`timescale 1ns/100ps
`include "pafs_cfg.svh"
module testbench;
  // ***************************
  // Signals, instances, helpers
  // ***************************
  logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic        debug_emulator_strap_n = 1'b1;
  logic [34:0] stim = '0;
  logic [2:0]  m0, m1, m2, m8, m9;
  logic [9:0]  pin_in, pin_out, pin_oe, port_out, port_oe, port_in;
  logic        serial0_clock_out, serial0_clock_oe, serial0_clock_in, serial0_transmit;
  logic        serial0_receive, serial2_transmit, serial2_receive, interrupt_request_0;
  logic        output_disable_request_0, output_disable_request_1, output_disable_request_8;
  logic        timer_ext_clock_c, timer_ext_clock_d, test_data_in, test_data_out, debug_active;
  int          miscompares = 0, n_compared = 0, cycles = 0;
  logic [2:0]  codes_a [3] = '{3'h0, 3'h1, 3'h7};
  logic [2:0]  codes_b [3] = '{3'h0, 3'h1, 3'h3};
  logic [2:0]  codes_c [3] = '{3'h0, 3'h1, 3'h6};
  logic [2:0]  codes_d [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
  pafs_top u_pafs_top (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .debug_emulator_strap_n, .pin_in, .pin_out, .pin_oe, .port_out, .port_oe, .port_in,
    .serial0_clock_out, .serial0_clock_oe, .serial0_clock_in, .serial0_transmit,
    .serial0_receive, .serial2_transmit, .serial2_receive, .interrupt_request_0,
    .output_disable_request_0, .output_disable_request_1, .output_disable_request_8,
    .timer_ext_clock_c, .timer_ext_clock_d, .test_data_in, .test_data_out, .debug_active);
  pafs_far_model u_pafs_far_model (.clk, .stim, .pin_out, .pin_oe, .pin_in, .port_out,
    .port_oe, .serial0_clock_out, .serial0_clock_oe, .serial0_transmit, .serial2_transmit,
    .test_data_out);
  initial forever #12.5 clk = ~clk;
  function automatic logic [1:0] dv(input logic oe, input logic o);
    return {oe, oe & o};
  endfunction : dv
  // Unselected peripheral inputs idle high.
  function automatic logic [7:0] exp_in();
    logic [9:0] p;
    p = stim[9:0];
    return {m0 == 3'h1 ? p[0] : 1'b1, m0 == 3'h7 ? p[0] : 1'b1, m1 == 3'h7 ? p[1] : 1'b1,
            m2 == 3'h3 ? p[2] : 1'b1, m8 == 3'h1 ? p[8] : 1'b1, m9 == 3'h1 ? p[9] : 1'b1,
            m8 == 3'h6 ? p[8] : 1'b1, m9 == 3'h7 ? p[9] : 1'b1};
  endfunction : exp_in
  function automatic logic [9:0] exp_drv();
    logic [9:0] po;
    logic [9:0] pe;
    po = stim[19:10];
    pe = stim[29:20];
    return {dv(m0 == 3'h0 & pe[0], po[0]),
            dv(m1 == 3'h0 ? pe[1] : m1 == 3'h1, m1 == 3'h0 ? po[1] : stim[32]),
            dv(m2 == 3'h0 ? pe[2] : m2 == 3'h1 & stim[31], m2 == 3'h0 ? po[2] : stim[30]),
            dv(m8 == 3'h0 & pe[8], po[8]),
            dv(m9 == 3'h0 ? pe[9] : m9 == 3'h6, m9 == 3'h0 ? po[9] : stim[33])};
  endfunction : exp_drv
  // A pad shows its driven value, else the outside level; port inputs follow the pad.
  function automatic logic [5:0] exp_pad();
    logic [9:0] e;
    logic [4:0] pad;
    e = exp_drv();
    pad = {e[9] ? e[8] : stim[0], e[7] ? e[6] : stim[1], e[5] ? e[4] : stim[2],
           e[3] ? e[2] : stim[8], e[1] ? e[0] : stim[9]};
    return {m2 == 3'h1 ? pad[2] : 1'b1, pad[0], pad[1], pad[2], pad[3], pad[4]};
  endfunction : exp_pad
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
    @(posedge clk);
  endtask : rd
  task automatic check_pins();
    check(16'({serial0_receive, output_disable_request_0, output_disable_request_1,
      interrupt_request_0, timer_ext_clock_c, timer_ext_clock_d, serial2_receive,
      output_disable_request_8}), 16'(exp_in()));
    check(16'({dv(pin_oe[0], pin_out[0]), dv(pin_oe[1], pin_out[1]), dv(pin_oe[2], pin_out[2]),
      dv(pin_oe[8], pin_out[8]), dv(pin_oe[9], pin_out[9])}), 16'(exp_drv()));
    check(16'({serial0_clock_in, port_in[9:8], port_in[2:0]}), 16'(exp_pad()));
  endtask : check_pins
  task automatic close_out();
    $display("%0d compared, %0d miscompares", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // A hang is cut off well beyond the 135 or so cycles the tests need.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    void'($urandom(32'h8D30));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`PAFS_OFS_LOW, 16'h0000);
    rd(`PAFS_OFS_PINS89, 16'h0000);
    rd(4'hC, 16'h0000);
    $display("test reset values done");
    wr(`PAFS_OFS_LOW, 16'hFFFF);
    rd(`PAFS_OFS_LOW, 16'h0777);
    wr(`PAFS_OFS_PINS89, 16'hFFFF);
    rd(`PAFS_OFS_PINS89, 16'h0077);
    wr(`PAFS_OFS_HIGH, 16'hFFFF);
    rd(`PAFS_OFS_HIGH, 16'h0000);
    $display("test reserved bits done");
    for (int i = 0; i < 12; i++) begin
      m0 = codes_a[i % 3];
      m1 = codes_a[(i + 1) % 3];
      m2 = codes_b[i % 3];
      m8 = codes_c[(i + 2) % 3];
      m9 = codes_d[i % 4];
      wr(`PAFS_OFS_LOW, {5'h00, m2, 1'b0, m1, 1'b0, m0});
      wr(`PAFS_OFS_PINS89, {9'h000, m9, 1'b0, m8});
      stim <= 35'({$urandom, $urandom});
      repeat (4) @(posedge clk);
      check_pins();
    end
    $display("test mode table done");
    debug_emulator_strap_n <= 1'b0;
    repeat (5) @(posedge clk);
    check(16'({debug_active, test_data_in, pin_oe[9], pin_out[9], port_in[8], timer_ext_clock_c}),
          16'({1'b1, stim[8], 1'b1, stim[34], 1'b1, 1'b1}));
    debug_emulator_strap_n <= 1'b1;
    repeat (5) @(posedge clk);
    check(16'(debug_active), 16'h0000);
    $display("test debug override done");
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    {m0, m1, m2, m8, m9} = '0;
    rd(`PAFS_OFS_LOW, 16'h0000);
    // The pad synchronisers refill after reset; let them settle first.
    repeat (2) @(posedge clk);
    check_pins();
    $display("test second reset done");
    close_out();
  end
endmodule : testbench
